/* rtl/card_cycle_timing.v */
// PC Card cycle timing generator with Avalon-MM register slave
//
// Our own choice: the Avalon-MM register port.
`timescale 1ns/1ps
module card_cycle_timing #(
  parameter CNT_W = 20
) (
  input wire i_core_clk,
  input wire i_reset,
  input wire [7:0] i_avs_address,
  input wire i_avs_read,
  input wire i_avs_write,
  input wire [31:0] i_avs_writedata,
  input wire [3:0] i_avs_byteenable,
  output reg [31:0] o_avs_readdata,
  output reg o_avs_waitrequest,
  input wire i_cycle_req,
  input wire [1:0] i_cycle_kind,
  input wire [7:0] i_window_ctrl,
  output reg o_cycle_ack,
  output reg o_busy,
  output reg o_oe_n,
  output reg o_we_n,
  output reg o_iord_n,
  output reg o_iowr_n
);
`include "card_timing_defs.vh"

  // ----------------------------------------
  // States
  // ----------------------------------------
  localparam ST_IDLE = 2'h0;
  localparam ST_SETUP = 2'h1;
  localparam ST_ACTIVE = 2'h2;
  localparam ST_RECOV = 2'h3;
  localparam [CNT_W-1:0] CNT_ONE = {{(CNT_W-1){1'b0}}, 1'b1};

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  reg [7:0] setup_length_set0_reg;
  reg [7:0] active_length_set0_reg;
  reg [7:0] recovery_length_set0_reg;
  reg [7:0] setup_length_set1_reg;
  reg [7:0] active_length_set1_reg;
  reg [7:0] recovery_length_set1_reg;
  reg force_set1_reg;
  reg ack_pending_reg;
  reg [1:0] state_reg;
  reg [1:0] state_next;
  reg [CNT_W-1:0] count_reg;
  reg [CNT_W-1:0] count_next;
  reg set_sel_reg;
  reg [1:0] kind_reg;

  wire [5:0] reg_index;
  wire bus_req;
  wire [7:0] setup_sel;
  wire [7:0] active_sel;
  wire [7:0] recov_sel;
  wire [CNT_W-1:0] setup_len;
  wire [CNT_W-1:0] active_len;
  wire [CNT_W-1:0] recov_len;
  wire start_set;
  wire use_set1;

  assign reg_index = i_avs_address[7:2];
  assign bus_req = i_avs_read | i_avs_write;

  // ----------------------------------------
  // Avalon-MM slave: one wait cycle, then answer
  // ----------------------------------------
  always @(posedge i_core_clk) begin
    if (i_reset) begin
      ack_pending_reg <= 1'b0;
      o_avs_waitrequest <= 1'b1;
    end else begin
      // Answer lands one cycle after request seen
      ack_pending_reg <= bus_req & o_avs_waitrequest & ~ack_pending_reg;
      o_avs_waitrequest <= ~(bus_req & o_avs_waitrequest & ~ack_pending_reg);
    end
  end

  wire bus_take = bus_req & ~o_avs_waitrequest;
  wire wr_lo = bus_take & i_avs_write & i_avs_byteenable[0];

  always @(posedge i_core_clk) begin
    if (i_reset) begin
      setup_length_set0_reg <= `RST_SETUP;
      active_length_set0_reg <= `RST_ACTIVE0;
      recovery_length_set0_reg <= `RST_RECOV;
      setup_length_set1_reg <= `RST_SETUP;
      active_length_set1_reg <= `RST_ACTIVE1;
      recovery_length_set1_reg <= `RST_RECOV;
      force_set1_reg <= 1'b0;
    end else if (wr_lo) begin
      // Writes act at once, even mid-cycle; keep the socket idle when changing
      case (reg_index)
        `IDX_SETUP0: setup_length_set0_reg <= i_avs_writedata[7:0];
        `IDX_ACTIVE0: active_length_set0_reg <= i_avs_writedata[7:0];
        `IDX_RECOV0: recovery_length_set0_reg <= i_avs_writedata[7:0];
        `IDX_SETUP1: setup_length_set1_reg <= i_avs_writedata[7:0];
        `IDX_ACTIVE1: active_length_set1_reg <= i_avs_writedata[7:0];
        `IDX_RECOV1: recovery_length_set1_reg <= i_avs_writedata[7:0];
        `IDX_CTRL: force_set1_reg <= i_avs_writedata[0];
        default: force_set1_reg <= force_set1_reg;
      endcase
    end
  end

  always @(posedge i_core_clk) begin
    if (i_reset) begin
      o_avs_readdata <= 32'h00000000;
    end else if (bus_req & o_avs_waitrequest & ~ack_pending_reg & i_avs_read) begin
      case (reg_index)
        `IDX_SETUP0: o_avs_readdata <= {24'h000000, setup_length_set0_reg};
        `IDX_ACTIVE0: o_avs_readdata <= {24'h000000, active_length_set0_reg};
        `IDX_RECOV0: o_avs_readdata <= {24'h000000, recovery_length_set0_reg};
        `IDX_SETUP1: o_avs_readdata <= {24'h000000, setup_length_set1_reg};
        `IDX_ACTIVE1: o_avs_readdata <= {24'h000000, active_length_set1_reg};
        `IDX_RECOV1: o_avs_readdata <= {24'h000000, recovery_length_set1_reg};
        `IDX_CTRL: o_avs_readdata <= {31'h0, force_set1_reg};
        `IDX_STATUS: o_avs_readdata <= {28'h0000000, set_sel_reg, state_reg, o_busy};
        default: o_avs_readdata <= 32'h00000000;
      endcase
    end
  end

  // ----------------------------------------
  // Timing set selection
  // ----------------------------------------
  assign start_set = i_window_ctrl[`WIN_SEL_LO] | i_window_ctrl[`WIN_SEL_HI] |
                     force_set1_reg;

  // Idle lengths track the set a new request would pick, so setup needs no lead cycle
  assign use_set1 = (state_reg == ST_IDLE) ? start_set : set_sel_reg;
  assign setup_sel = use_set1 ? setup_length_set1_reg : setup_length_set0_reg;
  assign active_sel = use_set1 ? active_length_set1_reg : active_length_set0_reg;
  assign recov_sel = use_set1 ? recovery_length_set1_reg : recovery_length_set0_reg;

  // ----------------------------------------
  // Phase lengths
  // ----------------------------------------
  // Lengths are registered, so they lag a write by one cycle
  phase_length_calc #(.CNT_W(CNT_W)) u_setup_len (
    .i_core_clk(i_core_clk),
    .i_reset(i_reset),
    .i_timing(setup_sel),
    .o_length(setup_len)
  );

  phase_length_calc #(.CNT_W(CNT_W)) u_active_len (
    .i_core_clk(i_core_clk),
    .i_reset(i_reset),
    .i_timing(active_sel),
    .o_length(active_len)
  );

  phase_length_calc #(.CNT_W(CNT_W)) u_recov_len (
    .i_core_clk(i_core_clk),
    .i_reset(i_reset),
    .i_timing(recov_sel),
    .o_length(recov_len)
  );

  // ----------------------------------------
  // Cycle sequencer
  // ----------------------------------------
  // count_reg counts core clocks already spent in the phase
  always @* begin
    state_next = state_reg;
    count_next = count_reg + CNT_ONE;
    case (state_reg)
      ST_IDLE: begin
        count_next = {CNT_W{1'b0}};
        if (i_cycle_req) begin
          state_next = ST_SETUP;
        end
      end
      ST_SETUP: begin
        if (count_reg + CNT_ONE >= setup_len) begin
          state_next = ST_ACTIVE;
          count_next = {CNT_W{1'b0}};
        end
      end
      ST_ACTIVE: begin
        if (count_reg + CNT_ONE >= active_len) begin
          state_next = ST_RECOV;
          count_next = {CNT_W{1'b0}};
        end
      end
      ST_RECOV: begin
        if (count_reg + CNT_ONE >= recov_len) begin
          state_next = ST_IDLE;
          count_next = {CNT_W{1'b0}};
        end
      end
      default: begin
        state_next = ST_IDLE;
        count_next = {CNT_W{1'b0}};
      end
    endcase
  end

  always @(posedge i_core_clk) begin
    if (i_reset) begin
      state_reg <= ST_IDLE;
      count_reg <= {CNT_W{1'b0}};
      set_sel_reg <= 1'b0;
      kind_reg <= `CMD_MEM_RD;
    end else begin
      state_reg <= state_next;
      count_reg <= count_next;
      if (state_reg == ST_IDLE && i_cycle_req) begin
        set_sel_reg <= start_set;
        kind_reg <= i_cycle_kind;
      end
    end
  end

  // ----------------------------------------
  // Strobes and handshake outputs
  // ----------------------------------------
  always @(posedge i_core_clk) begin
    if (i_reset) begin
      o_oe_n <= 1'b1;
      o_we_n <= 1'b1;
      o_iord_n <= 1'b1;
      o_iowr_n <= 1'b1;
      o_busy <= 1'b0;
      o_cycle_ack <= 1'b0;
    end else begin
      o_oe_n <= ~((state_next == ST_ACTIVE) && (kind_reg == `CMD_MEM_RD));
      o_we_n <= ~((state_next == ST_ACTIVE) && (kind_reg == `CMD_MEM_WR));
      o_iord_n <= ~((state_next == ST_ACTIVE) && (kind_reg == `CMD_IO_RD));
      o_iowr_n <= ~((state_next == ST_ACTIVE) && (kind_reg == `CMD_IO_WR));
      o_busy <= (state_next != ST_IDLE);
      o_cycle_ack <= (state_reg == ST_IDLE) && i_cycle_req;
    end
  end
endmodule // card_cycle_timing

/* rtl/card_timing_defs.vh */
// Constants for the PC Card cycle timing generator
`ifndef CARD_TIMING_DEFS_VH
`define CARD_TIMING_DEFS_VH

// Register offsets (printed offsets are indexes; byte address = index * 4)
`define IDX_SETUP0 6'h3A
`define IDX_ACTIVE0 6'h3B
`define IDX_RECOV0 6'h3C
`define IDX_SETUP1 6'h3D
`define IDX_ACTIVE1 6'h3E
`define IDX_RECOV1 6'h3F
`define IDX_CTRL 6'h38
`define IDX_STATUS 6'h39

// Reset values
`define RST_SETUP 8'h01
`define RST_ACTIVE0 8'h06
`define RST_ACTIVE1 8'h0F
`define RST_RECOV 8'h03

// Field layout
`define PRES_HI 7
`define PRES_LO 6
`define MULT_HI 5
`define MULT_LO 0

// Prescale weights
`define WEIGHT_00 14'h0001
`define WEIGHT_01 14'h0010
`define WEIGHT_10 14'h0100
`define WEIGHT_11 14'h2000

// Command kinds
`define CMD_MEM_RD 2'h0
`define CMD_MEM_WR 2'h1
`define CMD_IO_RD 2'h2
`define CMD_IO_WR 2'h3

// Window control bits that pick timing set 1
`define WIN_SEL_LO 3
`define WIN_SEL_HI 7

`endif

/* rtl/phase_length_calc.v */
// Phase length calculator: prescale weight times multiplier plus one
`timescale 1ns/1ps
module phase_length_calc #(
  parameter CNT_W = 20
) (
  input wire i_core_clk,
  input wire i_reset,
  input wire [7:0] i_timing,
  output reg [CNT_W-1:0] o_length
);
`include "card_timing_defs.vh"

  reg [13:0] prescale_weight;
  wire [5:0] multiplier_count;
  wire [CNT_W-1:0] product;

  assign multiplier_count = i_timing[`MULT_HI:`MULT_LO];

  always @* begin
    case (i_timing[`PRES_HI:`PRES_LO])
      2'h0: prescale_weight = `WEIGHT_00;
      2'h1: prescale_weight = `WEIGHT_01;
      2'h2: prescale_weight = `WEIGHT_10;
      default: prescale_weight = `WEIGHT_11;
    endcase
  end

  // 8192*63+1 fits in 20 bits
  assign product = {{(CNT_W-14){1'b0}}, prescale_weight} *
                   {{(CNT_W-6){1'b0}}, multiplier_count};

  always @(posedge i_core_clk) begin
    if (i_reset) begin
      o_length <= {CNT_W{1'b0}};
    end else begin
      o_length <= product + {{(CNT_W-1){1'b0}}, 1'b1};
    end
  end
endmodule // phase_length_calc

/* testbench/card_model.sv */
// Behavioural card that notes which command strobe it was given
`timescale 1ns/1ps
module card_model (
  input wire i_core_clk,
  input wire i_oe_n,
  input wire i_we_n,
  input wire i_iord_n,
  input wire i_iowr_n,
  output logic [1:0] o_kind
);
  always @(posedge i_core_clk) begin
    if (!i_oe_n) o_kind <= 2'h0;
    if (!i_we_n) o_kind <= 2'h1;
    if (!i_iord_n) o_kind <= 2'h2;
    if (!i_iowr_n) o_kind <= 2'h3;
  end
endmodule // card_model

/* testbench/card_timing_assertions.sv */
// Assertion checker for the card cycle timing generator
`timescale 1ns/1ps
module card_timing_checker #(
  parameter CNT_W = 20
) (
  input wire i_core_clk,
  input wire i_reset,
  input wire i_avs_read,
  input wire i_avs_write,
  input wire o_avs_waitrequest,
  input wire o_cycle_ack,
  input wire o_busy,
  input wire o_oe_n,
  input wire o_we_n,
  input wire o_iord_n,
  input wire o_iowr_n
);
  wire [3:0] strb_n = {o_oe_n, o_we_n, o_iord_n, o_iowr_n};
  wire quiet = &strb_n;
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_reset);
  property p_one_strobe; $onehot0(~strb_n); endproperty
  property p_strobe_busy; !quiet |-> o_busy; endproperty
  property p_ack_start; o_cycle_ack |-> $rose(o_busy); endproperty
  property p_ack_pulse; o_cycle_ack |=> !o_cycle_ack; endproperty
  // Setup is at least one cycle even with a zero count
  property p_setup_gap; $rose(o_busy) |-> quiet; endproperty
  property p_setup_first; $fell(quiet) |-> $past(o_busy); endproperty
  property p_steady; !quiet && !$past(quiet) |-> $stable(strb_n); endproperty
  property p_recovery; $rose(quiet) |-> o_busy; endproperty
  property p_busy_end; $fell(o_busy) |-> $past(quiet); endproperty
  property p_reg_answer;
    (i_avs_read || i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest;
  endproperty
  a_one_strobe: assert property (p_one_strobe)
    else $error("more than one strobe low");
  a_strobe_busy: assert property (p_strobe_busy)
    else $error("strobe low while idle");
  a_ack_start: assert property (p_ack_start)
    else $error("ack without new cycle");
  a_ack_pulse: assert property (p_ack_pulse)
    else $error("ack longer than one cycle");
  a_setup_gap: assert property (p_setup_gap)
    else $error("setup shorter than one cycle");
  a_setup_first: assert property (p_setup_first)
    else $error("strobe low without setup before it");
  a_steady: assert property (p_steady)
    else $error("strobe kind changed while active");
  a_recovery: assert property (p_recovery)
    else $error("no recovery after strobe");
  a_busy_end: assert property (p_busy_end)
    else $error("busy ended with strobe low");
  a_reg_answer: assert property (p_reg_answer)
    else $error("register access not answered");
  c_ack: cover property (o_cycle_ack);
  c_oe: cover property ($fell(o_oe_n));
  c_iowr: cover property ($fell(o_iowr_n));
endmodule // card_timing_checker

bind card_cycle_timing card_timing_checker #(.CNT_W(CNT_W)) chk_u (
  .i_core_clk(i_core_clk), .i_reset(i_reset),
  .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
  .o_avs_waitrequest(o_avs_waitrequest), .o_cycle_ack(o_cycle_ack),
  .o_busy(o_busy), .o_oe_n(o_oe_n), .o_we_n(o_we_n),
  .o_iord_n(o_iord_n), .o_iowr_n(o_iowr_n)
);

/* testbench/testbench.sv */
// Self-checking testbench for the card cycle timing generator
`timescale 1ns/1ps
module testbench;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic req = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic [1:0] kind = 2'h0;
  logic [7:0] win = 8'h00;
  logic force1 = 1'b0;
  logic [3:0] be = 4'hF;
  logic [31:0] scratch;
  wire [31:0] rdata;
  wire wait_req, ack, busy, oe_n, we_n, iord_n, iowr_n;
  wire [1:0] card_kind;
  wire [3:0] strb = {oe_n, we_n, iord_n, iowr_n};
  logic [7:0] shadow [6] = '{8'h01, 8'h06, 8'h03, 8'h01, 8'h0F, 8'h03};
  int miscompares = 0;
  int checked = 0;
  always #5 clk = ~clk;
  card_cycle_timing dut_u (
    .i_core_clk(clk), .i_reset(rst), .i_avs_address(addr), .i_avs_read(rd),
    .i_avs_write(wr), .i_avs_writedata({24'h000000, wdata}), .i_avs_byteenable(be),
    .o_avs_readdata(rdata), .o_avs_waitrequest(wait_req), .i_cycle_req(req),
    .i_cycle_kind(kind), .i_window_ctrl(win), .o_cycle_ack(ack), .o_busy(busy),
    .o_oe_n(oe_n), .o_we_n(we_n), .o_iord_n(iord_n), .o_iowr_n(iowr_n)
  );
  card_model card_u (.i_core_clk(clk), .i_oe_n(oe_n), .i_we_n(we_n),
    .i_iord_n(iord_n), .i_iowr_n(iowr_n), .o_kind(card_kind));
  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic report_and_stop;
    $display("Checked %0d, miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic hang;
    miscompares++;
    report_and_stop;
  endtask
  task automatic check(input [31:0] got, input [31:0] want);
    checked++;
    if (got !== want) begin
      miscompares++;
      $display("Error at %0t: got %0h expected %0h", $time, got, want);
    end
  endtask
  function automatic int len(input [7:0] r);
    int w[4] = '{1, 16, 256, 8192};
    return w[r[7:6]] * r[5:0] + 1;
  endfunction
  task automatic bus(input bit w, input [5:0] idx, input [7:0] d, output [31:0] q);
    int n;
    n = 0;
    addr <= {idx, 2'b00};
    wdata <= d;
    wr <= w;
    rd <= !w;
    do begin
      @(posedge clk);
      n++;
    end while (wait_req !== 1'b0 && n < 40);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    if (wait_req !== 1'b0) hang;
    @(posedge clk);
  endtask
  // Only called while the socket is idle, so no cycle sees a half change
  task automatic put(input [5:0] idx, input [7:0] d);
    logic [31:0] q;
    bus(1'b1, idx, d, q);
    if (idx >= 6'h3A) shadow[idx - 6'h3A] = d;
    if (idx == 6'h38) force1 = d[0];
  endtask
  task automatic get(input [5:0] idx, input [31:0] want);
    logic [31:0] q;
    bus(1'b0, idx, 8'h00, q);
    check(q, want);
  endtask
  task automatic span(input int sel, output int c);
    c = 1;
    forever begin
      @(posedge clk);
      if (sel == 0 ? (&strb) !== 1'b1 : sel == 1 ? (&strb) !== 1'b0 : busy !== 1'b1) break;
      c++;
      if (c > 20000) hang;
    end
  endtask
  task automatic cyc(input [1:0] k, input [7:0] w);
    int n, s, c, r, b;
    b = (w[3] | w[7] | force1) ? 3 : 0;
    n = 0;
    req <= 1'b1;
    kind <= k;
    win <= w;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 40);
    req <= 1'b0;
    if (ack !== 1'b1) hang;
    span(0, s);
    span(1, c);
    span(2, r);
    check(s, len(shadow[b]));
    check(c, len(shadow[b + 1]));
    check(r, len(shadow[b + 2]));
    check(card_kind, k);
  endtask
  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 6; i++) get(6'(6'h3A + i), shadow[i]);
    put(6'h10, 8'hA5);
    get(6'h10, 32'h00000000);
    for (int k = 0; k < 4; k++) cyc(2'(k), 8'h00);
    cyc(2'h1, 8'h08);
    cyc(2'h2, 8'h80);
    put(6'h3A, 8'h41);
    put(6'h3B, 8'h3F);
    put(6'h3C, 8'h00);
    put(6'h3D, 8'h00);
    for (int i = 0; i < 6; i++) get(6'(6'h3A + i), shadow[i]);
    cyc(2'h3, 8'h00);
    cyc(2'h0, 8'h88);
    put(6'h3A, 8'h00);
    put(6'h3B, 8'h81);
    put(6'h3C, 8'hC1);
    cyc(2'h1, 8'h00);
    be <= 4'hE;
    bus(1'b1, 6'h3C, 8'h55, scratch);
    be <= 4'hF;
    get(6'h3C, shadow[2]);
    put(6'h38, 8'h01);
    get(6'h38, 32'h00000001);
    cyc(2'h2, 8'h00);
    get(6'h39, 32'h00000008);
    put(6'h38, 8'h00);
    report_and_stop;
  end
endmodule // testbench
